/* rtl/ddh_device.sv */
/*
 Display driver end of the host port: parallel 6800/8080, 4-wire and
 3-wire serial, and i2c slave. Every pin is sampled through two flops
 of clk_in, so link edges must be several clk_in periods apart.
*/
`timescale 1ns/1ps
`include "ddh_cfg.svh"
module ddh_device #(
   parameter int COL_W = 8
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   ddh_link_if.dev_mp link,
   input wire logic [7:0] status_in,
   input wire logic [7:0] ram_rd_data_in,
   output logic wr_valid_out,
   output logic wr_is_data_out,
   output logic [7:0] wr_byte_out,
   output logic [COL_W-1:0] col_addr_out,
   output logic rd_done_out
);
   ddh_pkg::ddh_pins_t pin_now;
   ddh_pkg::ddh_pins_t s1_ff, s2_ff, s3_ff;
   ddh_pkg::ddh_i2c_st_t ist_ff, nxt_ist;
   logic [7:0] sh_ff, nxt_sh;
   logic [3:0] cnt_ff, nxt_cnt;
   logic rnw_ff, nxt_rnw;
   logic ctl_ff, nxt_ctl;
   logic cont_ff, nxt_cont;
   logic idc_ff, nxt_idc;
   logic [7:0] tx_ff, nxt_tx;
   logic [7:0] rdbuf_ff, nxt_rdbuf;
   logic [7:0] dout_ff, nxt_dout;
   logic doe_ff, nxt_doe;
   logic soe_ff, nxt_soe;
   logic wv_ff, nxt_wv;
   logic wd_ff, nxt_wd;
   logic [7:0] wb_ff, nxt_wb;
   logic [COL_W-1:0] col_ff, nxt_col;
   logic rdd_ff, nxt_rdd;
   logic m6800, m8080, mser, m3w, mi2c, cs;
   logic sck_r, sck_f, sda_r, sda_f, sda, i2c_start, i2c_stop;

   always_comb begin
      pin_now = '{isel: link.isel, cs_n: link.cs_n, dc: link.dc, rw: link.rw, e: link.e, d: link.d};
   end

   always_comb begin
      m6800 = (s2_ff.isel == `DDH_ISEL_6800);
      m8080 = (s2_ff.isel == `DDH_ISEL_8080);
      m3w = (s2_ff.isel == `DDH_ISEL_3W);
      mser = m3w || (s2_ff.isel == `DDH_ISEL_4W);
      mi2c = (s2_ff.isel == `DDH_ISEL_I2C);
      cs = ~s2_ff.cs_n;
      // pin 0 is the serial clock, pin 1 the serial data
      sck_r = ~s3_ff.d[`DDH_SCK_PIN] & s2_ff.d[`DDH_SCK_PIN];
      sck_f = s3_ff.d[`DDH_SCK_PIN] & ~s2_ff.d[`DDH_SCK_PIN];
      sda = s2_ff.d[`DDH_SDI_PIN];
      sda_r = ~s3_ff.d[`DDH_SDI_PIN] & sda;
      sda_f = s3_ff.d[`DDH_SDI_PIN] & ~sda;
      i2c_start = sda_f & s2_ff.d[`DDH_SCK_PIN] & s3_ff.d[`DDH_SCK_PIN];
      i2c_stop = sda_r & s2_ff.d[`DDH_SCK_PIN] & s3_ff.d[`DDH_SCK_PIN];
   end

   always_comb begin
      nxt_ist = ist_ff;
      nxt_sh = sh_ff;
      nxt_cnt = cnt_ff;
      nxt_rnw = rnw_ff;
      nxt_ctl = ctl_ff;
      nxt_cont = cont_ff;
      nxt_idc = idc_ff;
      nxt_tx = tx_ff;
      nxt_rdbuf = rdbuf_ff;
      nxt_soe = soe_ff;
      nxt_wv = 1'b0;
      nxt_wd = wd_ff;
      nxt_wb = wb_ff;
      nxt_rdd = 1'b0;
      nxt_doe = 1'b0;
      nxt_dout = s2_ff.dc ? rdbuf_ff : status_in;
      if (m6800 || m8080) begin
         // bus is driven only during a selected read strobe
         nxt_doe = cs & s2_ff.rw & (m6800 ? s2_ff.e : ~s2_ff.e);
         if (cs && (m6800 ? (s3_ff.e & ~s2_ff.e & ~s3_ff.rw) : (~s3_ff.rw & s2_ff.rw & s2_ff.e))) begin
            nxt_wv = 1'b1;
            nxt_wb = s3_ff.d;
            nxt_wd = s3_ff.dc;
         end
         if (cs && (m6800 ? (s3_ff.e & ~s2_ff.e & s3_ff.rw) : (~s3_ff.e & s2_ff.e & s2_ff.rw))) begin
            nxt_rdd = 1'b1;
            // read returns the earlier fetch, so the first one is a dummy
            if (s3_ff.dc) begin
               nxt_rdbuf = ram_rd_data_in;
            end
         end
      end
      // serial modes: no read path, data pins never driven
      if (mser) begin
         if (!cs) begin
            nxt_cnt = 4'h0;
         end else if (sck_r) begin
            nxt_sh = {sh_ff[6:0], sda};
            if (cnt_ff + 4'h1 == (m3w ? `DDH_SER3_BITS : `DDH_SER4_BITS)) begin
               nxt_cnt = 4'h0;
               nxt_wv = 1'b1;
               nxt_wb = {sh_ff[6:0], sda};
               nxt_wd = m3w ? sh_ff[7] : s2_ff.dc;
            end else begin
               nxt_cnt = cnt_ff + 4'h1;
            end
         end
      end
      if (!mi2c) begin
         nxt_ist = ddh_pkg::I_IDLE;
         nxt_soe = 1'b0;
      end else if (i2c_start) begin
         nxt_ist = ddh_pkg::I_ADDR;
         nxt_cnt = 4'h0;
         nxt_soe = 1'b0;
      end else if (i2c_stop) begin
         nxt_ist = ddh_pkg::I_IDLE;
         nxt_soe = 1'b0;
      end else begin
         unique case (ist_ff)
            ddh_pkg::I_IDLE, ddh_pkg::I_SKIP: begin
               nxt_soe = 1'b0;
            end
            ddh_pkg::I_ADDR, ddh_pkg::I_RX: begin
               if (sck_r) begin
                  nxt_sh = {sh_ff[6:0], sda};
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (sck_f && cnt_ff == `DDH_I2C_BITS) begin
                  nxt_ist = ddh_pkg::I_ACK;
                  nxt_soe = 1'b1;
                  if (ist_ff == ddh_pkg::I_ADDR) begin
                     if (sh_ff[7:1] == {`DDH_I2C_ADDR_HI, s2_ff.dc}) begin
                        nxt_rnw = sh_ff[0];
                        nxt_ctl = 1'b1;
                        nxt_cont = 1'b1;
                     end else begin
                        nxt_ist = ddh_pkg::I_SKIP;
                        nxt_soe = 1'b0;
                     end
                  end else if (ctl_ff) begin
                     nxt_cont = sh_ff[`DDH_CONT_BIT];
                     nxt_idc = sh_ff[`DDH_DC_BIT];
                     nxt_ctl = 1'b0;
                  end else begin
                     nxt_wv = 1'b1;
                     nxt_wb = sh_ff[7:0];
                     nxt_wd = idc_ff;
                     nxt_ctl = cont_ff;
                  end
               end
            end
            ddh_pkg::I_ACK: begin
               if (sck_f) begin
                  nxt_cnt = 4'h0;
                  if (rnw_ff) begin
                     // read mode sends one status byte, then waits for stop
                     nxt_ist = ddh_pkg::I_TX;
                     nxt_tx = status_in;
                     nxt_soe = ~status_in[7];
                  end else begin
                     nxt_ist = ddh_pkg::I_RX;
                     nxt_soe = 1'b0;
                  end
               end
            end
            ddh_pkg::I_TX: begin
               if (sck_r) begin
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (sck_f) begin
                  if (cnt_ff == `DDH_I2C_BITS) begin
                     nxt_ist = ddh_pkg::I_SKIP;
                     nxt_soe = 1'b0;
                  end else begin
                     nxt_tx = {tx_ff[6:0], 1'b0};
                     nxt_soe = ~tx_ff[6];
                  end
               end
            end
            default: begin
               nxt_ist = ddh_pkg::I_IDLE;
               nxt_soe = 1'b0;
            end
         endcase
      end
      nxt_col = col_ff;
      if (nxt_wv && nxt_wd) begin
         nxt_col = col_ff + {{(COL_W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         ist_ff <= ddh_pkg::I_IDLE;
         sh_ff <= 8'h00;
         cnt_ff <= 4'h0;
         rnw_ff <= 1'b0;
         ctl_ff <= 1'b0;
         cont_ff <= 1'b0;
         idc_ff <= 1'b0;
         tx_ff <= 8'h00;
         rdbuf_ff <= 8'h00;
         dout_ff <= 8'h00;
         doe_ff <= 1'b0;
         soe_ff <= 1'b0;
         wv_ff <= 1'b0;
         wd_ff <= 1'b0;
         wb_ff <= 8'h00;
         col_ff <= '0;
         rdd_ff <= 1'b0;
      end else begin
         s1_ff <= pin_now;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         ist_ff <= nxt_ist;
         sh_ff <= nxt_sh;
         cnt_ff <= nxt_cnt;
         rnw_ff <= nxt_rnw;
         ctl_ff <= nxt_ctl;
         cont_ff <= nxt_cont;
         idc_ff <= nxt_idc;
         tx_ff <= nxt_tx;
         rdbuf_ff <= nxt_rdbuf;
         dout_ff <= nxt_dout;
         doe_ff <= nxt_doe;
         soe_ff <= nxt_soe;
         wv_ff <= nxt_wv;
         wd_ff <= nxt_wd;
         wb_ff <= nxt_wb;
         col_ff <= nxt_col;
         rdd_ff <= nxt_rdd;
      end
   end

   // acknowledge only reaches the bus through the separate output pin
   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe = soe_ff;
   assign link.dev_d = dout_ff;
   assign link.dev_d_oe = doe_ff;
   assign wr_valid_out = wv_ff;
   assign wr_is_data_out = wd_ff;
   assign wr_byte_out = wb_ff;
   assign col_addr_out = col_ff;
   assign rd_done_out = rdd_ff;
endmodule : ddh_device

/* rtl/ddh_cfg.svh */
/*
 Constants for the display driver host port: strap codes, pin positions,
 frame lengths and host timing. Assumes a 100 MHz system clock.
*/
// Functional notes
// - strap pins choose one of five modes
// - 6800: read_write_select low write, high read
// - data_command_select low command/status, high data
// - 6800: byte taken at enable fall, chip selected
// - first display data read returns stale dummy
// - 8080: read strobe rise ends a read
// - 8080: byte taken at write strobe rise
// - 4-wire: shift msb first on clock rise
// - 4-wire: eighth clock samples dc, writes byte
// - serial modes are write only
// - 3-wire: 9-bit frame, flag then byte
// - 3-wire flag 1 data, 0 command
// - serial: pin 0 clock, pin 1 data
// - i2c address 011110 plus address_select_bit
// - foreign addresses are ignored entirely
// - direction bit 1 read, 0 write
// - i2c data split into input and output
// - control byte: continuation_flag, dc, six zeros
// - continuation_flag 0: all following bytes data
// - acknowledge every control and data byte
// - data write advances column pointer by one
`ifndef DDH_CFG_SVH
`define DDH_CFG_SVH
`define DDH_ISEL_4W 3'h0
`define DDH_ISEL_3W 3'h1
`define DDH_ISEL_I2C 3'h2
`define DDH_ISEL_6800 3'h4
`define DDH_ISEL_8080 3'h6
`define DDH_SCK_PIN 0
`define DDH_SDI_PIN 1
`define DDH_CONT_BIT 7
`define DDH_DC_BIT 6
`define DDH_I2C_ADDR_HI 6'h1E
`define DDH_SER4_BITS 4'h8
`define DDH_SER3_BITS 4'h9
`define DDH_I2C_BITS 4'h8
`define DDH_H_NB4 5'h08
`define DDH_H_NB3 5'h09
`define DDH_H_NBI2C 5'h1B
`define DDH_REG_MODE 2'h0
`define DDH_REG_TX 2'h1
`define DDH_REG_RX 2'h2
`define DDH_REG_STAT 2'h3
`define DDH_TX_DC_BIT 8
`define DDH_ALSB_BIT 3
`define DDH_CLK_NS 10
`define DDH_HALF_NS 60
`define DDH_HALF_CYC ((`DDH_HALF_NS + `DDH_CLK_NS - 1) / `DDH_CLK_NS)
`endif

/* rtl/ddh_pkg.sv */
/*
 Types shared by both ends of the display driver host port.
 Assumes ddh_cfg.svh is on the include path.
*/
`include "ddh_cfg.svh"
package ddh_pkg;
   typedef struct packed {
      logic [2:0] isel;
      logic cs_n;
      logic dc;
      logic rw;
      logic e;
      logic [7:0] d;
   } ddh_pins_t;
   typedef enum logic [5:0] {
      I_IDLE = 6'h01, I_ADDR = 6'h02, I_ACK = 6'h04, I_RX = 6'h08, I_TX = 6'h10, I_SKIP = 6'h20
   } ddh_i2c_st_t;
   typedef enum logic [4:0] {
      H_IDLE = 5'h01, H_PAR = 5'h02, H_BIT = 5'h04, H_STA = 5'h08, H_STO = 5'h10
   } ddh_host_st_t;
endpackage : ddh_pkg

/* rtl/ddh_link_if.sv */
/*
 Pin-level link between the host controller and the display driver port.
 Resolves the shared data bus; i2c data line is open drain with pull-up.
*/
`timescale 1ns/1ps
`include "ddh_cfg.svh"
interface ddh_link_if;
   logic [2:0] isel;
   logic cs_n;
   logic dc;
   logic rw;
   logic e;
   logic [7:0] host_d;
   logic host_d_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic [7:0] dev_d;
   logic dev_d_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic [7:0] d;
   // undriven data pins read low, as if tied, except the i2c data pin, which is pulled high
   always_comb begin
      d = dev_d_oe ? dev_d : (host_d_oe ? host_d : 8'h00);
      if (isel == `DDH_ISEL_I2C) begin
         d[`DDH_SDI_PIN] = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
      end
   end
   modport dev_mp (input isel, cs_n, dc, rw, e, d, output dev_d, dev_d_oe, dev_sda_o, dev_sda_oe);
   modport host_mp (input d, output isel, cs_n, dc, rw, e, host_d, host_d_oe, host_sda_o, host_sda_oe);
endinterface : ddh_link_if

/* rtl/ddh_host.sv */
/*
 Host controller end: takes orders through a small register port and
 drives the link in the strapped mode. Link timing steps every HALF_CYC
 clocks; the acknowledge is ignored so a missing output pin is harmless.
*/
`timescale 1ns/1ps
`include "ddh_cfg.svh"
module ddh_host #(
   parameter logic [7:0] HALF_CYC = 8'(`DDH_HALF_CYC)
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   ddh_link_if.host_mp link,
   input wire logic [1:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out
);
   ddh_pkg::ddh_host_st_t st_ff, nxt_st;
   logic [3:0] mode_ff, nxt_mode;
   logic [1:0] step_ff, nxt_step;
   logic [7:0] div_ff, nxt_div;
   logic [26:0] vec_ff, nxt_vec;
   logic [4:0] nb_ff, nxt_nb;
   logic [4:0] cnt_ff, nxt_cnt;
   logic read_ff, nxt_read;
   logic dcp_ff, nxt_dcp;
   logic [7:0] rx_ff, nxt_rx;
   logic [7:0] dsy1_ff, dsy2_ff;
   logic [15:0] rd_ff, nxt_rd;
   logic cs_n_ff, nxt_cs_n;
   logic dc_ff, nxt_dc;
   logic rw_ff, nxt_rw;
   logic e_ff, nxt_e;
   logic [7:0] do_ff, nxt_do;
   logic doe_ff, nxt_doe;
   logic soe_ff, nxt_soe;
   logic tick, m6800, m8080, m3w, mi2c, par, addr_lsb;

   always_comb begin
      tick = (div_ff == 8'h00);
      m6800 = (mode_ff[2:0] == `DDH_ISEL_6800);
      m8080 = (mode_ff[2:0] == `DDH_ISEL_8080);
      m3w = (mode_ff[2:0] == `DDH_ISEL_3W);
      mi2c = (mode_ff[2:0] == `DDH_ISEL_I2C);
      par = m6800 | m8080;
      addr_lsb = mode_ff[`DDH_ALSB_BIT];
      nxt_div = tick ? HALF_CYC - 8'h01 : div_ff - 8'h01;
      nxt_st = st_ff;
      nxt_mode = mode_ff;
      nxt_step = step_ff;
      nxt_vec = vec_ff;
      nxt_nb = nb_ff;
      nxt_cnt = cnt_ff;
      nxt_read = read_ff;
      nxt_dcp = dcp_ff;
      nxt_rx = rx_ff;
      nxt_cs_n = cs_n_ff;
      nxt_dc = dc_ff;
      nxt_rw = rw_ff;
      nxt_e = e_ff;
      nxt_do = do_ff;
      nxt_doe = doe_ff;
      nxt_soe = soe_ff;
      nxt_rd = rd_ff;
      if (rd_in) begin
         nxt_rd = (addr_in == `DDH_REG_STAT) ? {rx_ff, 7'h00, st_ff != ddh_pkg::H_IDLE} : {12'h000, mode_ff};
      end
      unique case (st_ff)
         ddh_pkg::H_IDLE: begin
            nxt_cs_n = 1'b1;
            nxt_dc = mi2c ? addr_lsb : (m3w ? 1'b0 : dc_ff);
            nxt_e = m8080;
            nxt_rw = m8080;
            nxt_doe = ~par;
            nxt_do = mi2c ? 8'h01 : 8'h00;
            nxt_soe = 1'b0;
            nxt_step = 2'h0;
            nxt_cnt = 5'h00;
            if (wr_in && addr_in == `DDH_REG_MODE) begin
               nxt_mode = wdata_in[3:0];
            end else if (wr_in && addr_in == `DDH_REG_TX) begin
               nxt_read = 1'b0;
               nxt_dcp = wdata_in[`DDH_TX_DC_BIT];
               nxt_do = par ? wdata_in[7:0] : nxt_do;
               nxt_st = par ? ddh_pkg::H_PAR : (mi2c ? ddh_pkg::H_STA : ddh_pkg::H_BIT);
               nxt_nb = mi2c ? `DDH_H_NBI2C : (m3w ? `DDH_H_NB3 : `DDH_H_NB4);
               if (mi2c) begin
                  // address+write, control byte with continuation_flag 0, data
                  nxt_vec = {`DDH_I2C_ADDR_HI, addr_lsb, 1'b0, 1'b1, 1'b0, wdata_in[`DDH_TX_DC_BIT], 6'h00, 1'b1,
                             wdata_in[7:0], 1'b1};
               end else if (m3w) begin
                  nxt_vec = {wdata_in[`DDH_TX_DC_BIT], wdata_in[7:0], 18'h00000};
               end else begin
                  nxt_vec = {wdata_in[7:0], 19'h00000};
                  nxt_dc = wdata_in[`DDH_TX_DC_BIT];
               end
            end else if (wr_in && addr_in == `DDH_REG_RX && par) begin
               // reads exist only in parallel modes
               nxt_read = 1'b1;
               nxt_dcp = wdata_in[0];
               nxt_st = ddh_pkg::H_PAR;
            end
         end
         ddh_pkg::H_PAR: begin
            if (tick) begin
               nxt_step = step_ff + 2'h1;
               unique case (step_ff)
                  2'h0: begin
                     nxt_cs_n = 1'b0;
                     nxt_dc = dcp_ff;
                     nxt_rw = m6800 ? read_ff : 1'b1;
                     nxt_doe = ~read_ff;
                  end
                  2'h1: begin
                     nxt_e = m6800 ? 1'b1 : ~read_ff;
                     nxt_rw = m6800 ? read_ff : read_ff;
                  end
                  2'h2: begin
                     nxt_rx = read_ff ? dsy2_ff : rx_ff;
                     nxt_e = m8080;
                     nxt_rw = m6800 ? read_ff : 1'b1;
                  end
                  default: begin
                     nxt_cs_n = 1'b1;
                     nxt_doe = 1'b0;
                     nxt_st = ddh_pkg::H_IDLE;
                  end
               endcase
            end
         end
         ddh_pkg::H_BIT: begin
            if (tick) begin
               nxt_step = step_ff + 2'h1;
               if (step_ff == 2'h0) begin
                  nxt_cs_n = mi2c;
                  nxt_soe = mi2c & ~vec_ff[26];
                  nxt_do[`DDH_SDI_PIN] = ~mi2c & vec_ff[26];
               end else if (step_ff == 2'h1) begin
                  nxt_do[`DDH_SCK_PIN] = 1'b1;
               end else begin
                  nxt_do[`DDH_SCK_PIN] = 1'b0;
                  nxt_vec = {vec_ff[25:0], 1'b0};
                  nxt_cnt = cnt_ff + 5'h01;
                  nxt_step = 2'h0;
                  if (cnt_ff + 5'h01 == nb_ff) begin
                     nxt_st = mi2c ? ddh_pkg::H_STO : ddh_pkg::H_IDLE;
                     nxt_cs_n = 1'b1;
                  end
               end
            end
         end
         ddh_pkg::H_STA: begin
            if (tick) begin
               nxt_step = step_ff + 2'h1;
               if (step_ff == 2'h0) begin
                  nxt_soe = 1'b1;
               end else begin
                  nxt_do[`DDH_SCK_PIN] = 1'b0;
                  nxt_step = 2'h0;
                  nxt_st = ddh_pkg::H_BIT;
               end
            end
         end
         ddh_pkg::H_STO: begin
            if (tick) begin
               nxt_step = step_ff + 2'h1;
               if (step_ff == 2'h0) begin
                  nxt_soe = 1'b1;
               end else if (step_ff == 2'h1) begin
                  nxt_do[`DDH_SCK_PIN] = 1'b1;
               end else begin
                  nxt_soe = 1'b0;
                  nxt_st = ddh_pkg::H_IDLE;
               end
            end
         end
         default: nxt_st = ddh_pkg::H_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_ff <= ddh_pkg::H_IDLE;
         mode_ff <= 4'h0;
         step_ff <= 2'h0;
         div_ff <= 8'h00;
         vec_ff <= 27'h0000000;
         nb_ff <= 5'h00;
         cnt_ff <= 5'h00;
         read_ff <= 1'b0;
         dcp_ff <= 1'b0;
         rx_ff <= 8'h00;
         dsy1_ff <= 8'h00;
         dsy2_ff <= 8'h00;
         rd_ff <= 16'h0000;
         cs_n_ff <= 1'b1;
         dc_ff <= 1'b0;
         rw_ff <= 1'b0;
         e_ff <= 1'b0;
         do_ff <= 8'h00;
         doe_ff <= 1'b0;
         soe_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         mode_ff <= nxt_mode;
         step_ff <= nxt_step;
         div_ff <= nxt_div;
         vec_ff <= nxt_vec;
         nb_ff <= nxt_nb;
         cnt_ff <= nxt_cnt;
         read_ff <= nxt_read;
         dcp_ff <= nxt_dcp;
         rx_ff <= nxt_rx;
         dsy1_ff <= link.d;
         dsy2_ff <= dsy1_ff;
         rd_ff <= nxt_rd;
         cs_n_ff <= nxt_cs_n;
         dc_ff <= nxt_dc;
         rw_ff <= nxt_rw;
         e_ff <= nxt_e;
         do_ff <= nxt_do;
         doe_ff <= nxt_doe;
         soe_ff <= nxt_soe;
      end
   end

   assign link.isel = mode_ff[2:0];
   assign link.cs_n = cs_n_ff;
   assign link.dc = dc_ff;
   assign link.rw = rw_ff;
   assign link.e = e_ff;
   assign link.host_d = do_ff;
   assign link.host_d_oe = doe_ff;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe = soe_ff;
   assign rdata_out = rd_ff;
endmodule : ddh_host

/* verif/ddh_link_checker.sv */
/*
 Link-level checks between host and driver ends of the display port.
 Sees only the link signals; instanced beside the link in the bench.
*/
`timescale 1ns/1ps
`include "ddh_cfg.svh"
module ddh_link_checker (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [2:0] isel,
   input wire logic cs_n,
   input wire logic rw,
   input wire logic e,
   input wire logic [7:0] d,
   input wire logic host_d_oe,
   input wire logic dev_d_oe,
   input wire logic dev_sda_oe
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   wire par = (isel == `DDH_ISEL_6800) || (isel == `DDH_ISEL_8080);
   wire ser = (isel == `DDH_ISEL_4W) || (isel == `DDH_ISEL_3W);
   sequence ack_hold;
      dev_sda_oe [*3];
   endsequence
   sequence rd8080_end;
      (isel == `DDH_ISEL_8080) && dev_d_oe ##1 $rose(e);
   endsequence
   par_drive_a: assert property (dev_d_oe |-> par) else $error("read drive outside parallel mode");
   ack_mode_a: assert property (dev_sda_oe |-> isel == `DDH_ISEL_I2C) else $error("sda pull outside i2c");
   ack_hold_a: assert property ($rose(dev_sda_oe) |-> ack_hold) else $error("ack pull too short");
   rd6800_drive_a: assert property ($rose(dev_d_oe) && isel == `DDH_ISEL_6800 |-> rw && e && !cs_n)
      else $error("6800 drive without read cycle");
   rd8080_drive_a: assert property ($rose(dev_d_oe) && isel == `DDH_ISEL_8080 |-> !e && rw && !cs_n)
      else $error("8080 drive without read strobe");
   rd_release_a: assert property (rd8080_end |-> ##[1:6] !dev_d_oe) else $error("bus kept after read");
   bus_fight_a: assert property (!(host_d_oe && dev_d_oe)) else $error("both ends drive data");
   ser_tie_a: assert property (ser && host_d_oe |-> d[7:2] == 6'h00 && !rw && !e)
      else $error("unused serial pins not low");
   latch_cs_a: assert property (isel == `DDH_ISEL_6800 && $fell(e) && !rw |-> !cs_n)
      else $error("6800 latch without select");
   sclk_cs_a: assert property (ser && $rose(d[0]) |-> !cs_n) else $error("serial clock unselected");
endmodule : ddh_link_checker

/* verif/ddh_tb_top.sv */
/*
 Bench joining host and driver ends over the link in every strap mode.
 Drives the host register port, watches the driver's user outputs.
*/
`timescale 1ns/1ps
`include "ddh_cfg.svh"
module ddh_tb_top;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [7:0] stat = 8'h00;
   logic [7:0] ram = 8'h00;
   logic [15:0] rdata;
   logic wv, isd, rdd;
   logic [7:0] wb, col;
   int n_fail = 0;
   int check_count = 0;
   int nwr = 0;
   int nrd = 0;
   int seed = 32'h5ABF;
   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      nwr <= nwr + int'(wv === 1'b1);
      nrd <= nrd + int'(rdd === 1'b1);
   end
   ddh_link_if link ();
   ddh_host ddh_host_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata));
   ddh_device ddh_device_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link), .status_in(stat),
      .ram_rd_data_in(ram), .wr_valid_out(wv), .wr_is_data_out(isd), .wr_byte_out(wb), .col_addr_out(col),
      .rd_done_out(rdd));
   ddh_link_checker ddh_link_checker_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .isel(link.isel), .cs_n(link.cs_n),
      .rw(link.rw), .e(link.e), .d(link.d), .host_d_oe(link.host_d_oe), .dev_d_oe(link.dev_d_oe),
      .dev_sda_oe(link.dev_sda_oe));
   task stop_test;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task wr(input logic [1:0] a, input logic [15:0] v);
      @(posedge clk_in);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk_in);
      wr_s <= 1'b0;
   endtask : wr
   task rd(input logic [1:0] a, output logic [15:0] v);
      @(posedge clk_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_in);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask : rd
   // device answers 3 clocks after the last link edge, so settle 8
   task wait_idle;
      logic [15:0] v;
      int k;
      for (k = 0; k < 4000; k++) begin
         rd(2'h3, v);
         if (v[0] === 1'b0) break;
      end
      if (k == 4000) begin
         n_fail++;
         stop_test();
      end
      repeat (8) @(posedge clk_in);
   endtask : wait_idle
   initial begin : main
      logic [2:0] modes [5] = '{`DDH_ISEL_4W, `DDH_ISEL_3W, `DDH_ISEL_I2C, `DDH_ISEL_6800, `DDH_ISEL_8080};
      logic [15:0] v;
      logic [7:0] b, rb;
      logic dc;
      int i, k, ecol, ewr, erd;
      ecol = 0;
      ewr = 0;
      erd = 0;
      rb = 8'h00;
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      for (i = 0; i < 5; i++) begin
         dc = 1'($random(seed));
         wr(2'h0, {12'h000, dc, modes[i]});
         rd(2'h0, v);
         chk("mode", v, {12'h000, dc, modes[i]});
         repeat (5) @(posedge clk_in);
         for (k = 0; k < 4; k++) begin
            b = (k == 0) ? 8'h80 : (k == 1) ? 8'h01 : 8'($random(seed));
            dc = (k == 1) ? 1'b1 : 1'($random(seed));
            wr(2'h1, {7'h00, dc, b});
            wait_idle();
            ewr++;
            ecol += int'(dc);
            chk("byte", {8'h00, wb}, {8'h00, b});
            chk("dc", {15'h0000, isd}, {15'h0000, dc});
            chk("col", {8'h00, col}, {8'h00, 8'(ecol)});
            chk("writes", 16'(nwr), 16'(ewr));
         end
         if (modes[i] == `DDH_ISEL_6800 || modes[i] == `DDH_ISEL_8080) begin
            stat <= 8'($random(seed));
            wr(2'h2, 16'h0000);
            wait_idle();
            rd(2'h3, v);
            chk("status", {8'h00, v[15:8]}, {8'h00, stat});
            for (k = 0; k < 2; k++) begin
               ram <= 8'($random(seed));
               wr(2'h2, 16'h0001);
               wait_idle();
               rd(2'h3, v);
               chk("rdata", {8'h00, v[15:8]}, {8'h00, rb});
               rb = ram;
            end
            erd += 3;
            chk("reads", 16'(nrd), 16'(erd));
         end else begin
            // serial read order must be refused, busy stays low
            wr(2'h2, 16'h0001);
            rd(2'h3, v);
            chk("busy", {15'h0000, v[0]}, 16'h0000);
         end
         $display("test mode %0h done", modes[i]);
      end
      stop_test();
   end
endmodule : ddh_tb_top
